// ==== src/spim_pkg.sv ====
// Purpose: Shared constants and types for the serial master block
// Assumes: 100 MHz core clock
// Notes:   Widths that may vary are also module parameters
package spim_pkg;

    // Core clock and serial clock limits in Hz
    localparam int CORE_CLK_HZ = 100_000_000;
    localparam int SCLK_MAX_HZ = 16_000_000;
    localparam int SCLK_MIN_HZ = 125_000;

    // Half-period bounds in core cycles: least rounds up, longest down
    localparam int HALF_MIN_CYC =
        (CORE_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
    localparam int HALF_MAX_CYC = CORE_CLK_HZ / (2 * SCLK_MIN_HZ);

    // Widths
    localparam int SPIM_DATA_W = 32;
    localparam int SPIM_SEL_N  = 5;
    localparam int SPIM_DIV_W  = 9;
    localparam int SPIM_EDGE_W = 7;
    localparam int SPIM_FIFO_D = 8;

    // Reset values
    localparam logic [SPIM_DIV_W-1:0]  DIV_RST  = 9'h000;
    localparam logic [SPIM_EDGE_W-1:0] EDGE_RST = 7'h00;
    localparam logic [SPIM_SEL_N-1:0]  SEL_RST  = 5'h1F;
    localparam logic [SPIM_DATA_W-1:0] WORD_RST = 32'h0000_0000;

    // Transaction set-up, captured when a word is taken
    typedef struct packed {
        logic       cpol;         // Clock idle level
        logic       cpha;         // Launch on leading edge when set
        logic       lsb_first;    // Bit order
        logic       late_sample;  // Sample half a period later
        logic [4:0] len_m1;       // Transaction length minus one
        logic [2:0] sel_idx;      // Select used in automatic mode
        logic       auto_sel;     // Automatic select handling
    } spim_cfg_t;

    localparam spim_cfg_t CFG_RST = '0;

    // Engine states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_SHIFT = 2'b10,
        ST_GAP   = 2'b11
    } spim_state_t;

endpackage

// ==== src/spim_sync2.sv ====
// Purpose: Two-stage synchroniser for one pin input
// Assumes: Input is asynchronous to core_clk_in
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module spim_sync2
    import spim_pkg::*;
(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // Data
    input  wire logic d_in,
    output logic      q_out
);

    logic meta_reg;   // First stage, may be metastable
    logic sync_reg;   // Second stage, safe to use

    // Two flops, no logic between them
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end
        else
        begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;

endmodule // spim_sync2

// ==== src/spim_fifo.sv ====
// Purpose: Transmit word buffer between the user port and the engine
// Assumes: One push and one pop per cycle at most each
// Notes:   Ready and valid are flops so the top sees clean outputs
`timescale 1ns/1ps
module spim_fifo
    import spim_pkg::*;
#(
    parameter int W     = SPIM_DATA_W,
    parameter int DEPTH = SPIM_FIFO_D
)
(
    // Clock and reset
    input  wire logic         core_clk_in,
    input  wire logic         rst_n_in,
    // Fill side
    input  wire logic         in_valid_in,
    input  wire logic [W-1:0] in_data_in,
    output logic              in_ready_out,
    // Drain side
    output logic              out_valid_out,
    output logic [W-1:0]      out_data_out,
    input  wire logic         out_ready_in
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    logic [W-1:0]  mem [DEPTH];         // Word storage
    logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
    logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
    logic [CW-1:0] count_reg, count_next;
    logic          ready_reg, ready_next;
    logic          valid_reg, valid_next;
    logic          push, pop;

    // Pointer and level update
    always_comb
    begin
        push        = in_valid_in && ready_reg;
        pop         = out_ready_in && valid_reg;
        wr_ptr_next = push ? AW'((wr_ptr_reg + 1'b1) % DEPTH) : wr_ptr_reg;
        rd_ptr_next = pop ? AW'((rd_ptr_reg + 1'b1) % DEPTH) : rd_ptr_reg;
        count_next  = count_reg + CW'(push) - CW'(pop);
        ready_next  = count_next != FULL_CNT;   // Honest full
        valid_next  = count_next != '0;         // Honest empty
    end

    // State registers
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
            ready_reg  <= 1'b0;
            valid_reg  <= 1'b0;
        end
        else
        begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
            ready_reg  <= ready_next;
            valid_reg  <= valid_next;
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge core_clk_in)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data_in;
    end

    assign in_ready_out  = ready_reg;
    assign out_valid_out = valid_reg;
    assign out_data_out  = mem[rd_ptr_reg];

    // Full buffer refuses words
    property p_full_stall;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (count_reg == FULL_CNT) |-> !in_ready_out;
    endproperty
    a_full_stall: assert property (p_full_stall) // RQ13
        else $error("fifo accepts while full");

endmodule // spim_fifo

// ==== src/spim_master.sv ====
// Purpose: Serial peripheral master with five selects and word buffer
// Assumes: 100 MHz core clock, set-up bits driven by local logic
// Notes:   Config is captured when a buffered word is taken
//
// Behaviour
// [RQ1] Block is master and drives serial clock
// [RQ2] Each shifted-out bit shifts one bit in
// [RQ3] Length 1 to 32 bits, runs unattended
// [RQ4] Divider sets clock between 16 MHz, 125 kHz (clamp tops out at 12.5 MHz here)
// [RQ5] Mode 0: idle low, out falling, in rising
// [RQ6] Mode 1: idle low, out rising, in falling
// [RQ7] Mode 2: idle high, out rising, in falling
// [RQ8] Mode 3: idle high, out falling, in rising
// [RQ9] Five active-low slave selects
// [RQ10] Software uses selects in order, no gaps
// [RQ11] Auto select drops between transactions, manual holds
// [RQ12] Software uses manual select for flash reads
// [RQ13] Config, select, then load data to shift
// [RQ14] Received bits equal transmitted bits, readable
// [RQ15] Software sends dummy data to read only
// [RQ16] Completion sets status and masked interrupt
// [RQ17] Config chooses LSB or MSB first
// [RQ18] Option delays the input sampling edge
// [RQ19] Reset leaves block idle, selects high
// [RQ20] Delayed sample moves half a period later
`timescale 1ns/1ps
module spim_master
    import spim_pkg::*;
(
    // Clock and reset
    input  wire logic                   core_clk_in,
    input  wire logic                   rst_n_in,
    // Set-up and control
    input  wire spim_cfg_t              cfg_in,
    input  wire logic [SPIM_DIV_W-1:0]  half_div_in,
    input  wire logic [SPIM_SEL_N-1:0]  manual_sel_in,
    input  wire logic                   irq_en_in,
    input  wire logic                   done_clr_in,
    // Transmit words
    input  wire logic                   tx_valid_in,
    input  wire logic [SPIM_DATA_W-1:0] tx_data_in,
    output logic                        tx_ready_out,
    // Received words and status
    output logic [SPIM_DATA_W-1:0]      rx_data_out,
    output logic                        rx_valid_out,
    output logic                        busy_out,
    output logic                        done_out,
    output logic                        irq_out,
    // Serial pins
    output logic                        serial_clk_out,
    output logic                        master_out_line_out,
    input  wire logic                   master_in_line_in,
    output logic                        slave_select_zero_n_out,
    output logic                        slave_select_one_n_out,
    output logic                        slave_select_two_n_out,
    output logic                        slave_select_three_n_out,
    output logic                        slave_select_four_n_out
);

    localparam logic [SPIM_DIV_W-1:0] HALF_LO = SPIM_DIV_W'(HALF_MIN_CYC);
    localparam logic [SPIM_DIV_W-1:0] HALF_HI = SPIM_DIV_W'(HALF_MAX_CYC);

    // Buffer drain side and synchronised input
    logic                   fifo_valid;     // Word waiting
    logic [SPIM_DATA_W-1:0] fifo_data;      // Head word
    logic                   fifo_pop;       // Engine takes head
    logic                   miso_sync;      // Synchronised input line

    // Engine state
    spim_state_t             state_reg, state_next;
    spim_cfg_t               cfg_reg, cfg_next;       // Captured set-up
    logic [SPIM_DIV_W-1:0]   half_reg, half_next;     // Half period
    logic [SPIM_DIV_W-1:0]   cnt_reg, cnt_next;       // Cycle counter
    logic [SPIM_EDGE_W-1:0]  edge_reg, edge_next;     // Edge index
    logic [SPIM_DATA_W-1:0]  tx_sh_reg, tx_sh_next;   // Outgoing bits
    logic [SPIM_DATA_W-1:0]  rx_sh_reg, rx_sh_next;   // Incoming bits
    logic                    sclk_reg, sclk_next;
    logic                    mosi_reg, mosi_next;
    logic [SPIM_SEL_N-1:0]   sel_n_reg, sel_n_next;

    // Answers and status
    logic [SPIM_DATA_W-1:0]  rx_word_reg, rx_word_next;
    logic                    rx_valid_reg, rx_valid_next;
    logic                    done_reg, done_next;
    logic                    irq_reg, irq_next;
    logic                    busy_reg, busy_next;

    // Helpers
    logic                    tick;          // Half period elapsed
    logic [SPIM_EDGE_W-1:0]  last_edge;     // Twice the length
    logic                    launch, sample, finish;
    logic [SPIM_DATA_W-1:0]  rx_cur;        // Incoming bits incl. this one
    logic [SPIM_DATA_W-1:0]  aligned;       // Word as loaded
    logic [SPIM_SEL_N-1:0]   auto_vec;
    logic [SPIM_EDGE_W-1:0]  first_smp;
    logic [SPIM_EDGE_W-1:0]  toggles_reg;   // Clock edges this transfer

    // Word buffer in the transmit path
    spim_fifo #(
        .W     (SPIM_DATA_W),
        .DEPTH (SPIM_FIFO_D)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (tx_valid_in),
        .in_data_in    (tx_data_in),
        .in_ready_out  (tx_ready_out),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_data),
        .out_ready_in  (fifo_pop)
    );

    // Input pin crosses two flops before use
    spim_sync2 u_miso_sync (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .d_in        (master_in_line_in),
        .q_out       (miso_sync)
    );

    // Engine next-state logic
    always_comb
    begin
        state_next    = state_reg;
        cfg_next      = cfg_reg;
        half_next     = half_reg;
        cnt_next      = cnt_reg;
        edge_next     = edge_reg;
        tx_sh_next    = tx_sh_reg;
        rx_sh_next    = rx_sh_reg;
        sclk_next     = sclk_reg;
        mosi_next     = mosi_reg;
        rx_word_next  = rx_word_reg;
        rx_valid_next = 1'b0;
        fifo_pop      = 1'b0;
        finish        = 1'b0;
        launch        = 1'b0;
        sample        = 1'b0;
        // Tick paces every clock edge
        tick      = (state_reg != ST_IDLE) && (cnt_reg == half_reg - 1'b1);
        last_edge = SPIM_EDGE_W'({cfg_reg.len_m1, 1'b0}) + 7'h02;
        // Later sampling shifts the first sample one edge on
        first_smp = SPIM_EDGE_W'(cfg_reg.cpha) +
                    SPIM_EDGE_W'(cfg_reg.late_sample);          // RQ20
        // MSB-first words are pushed to the top before shifting
        aligned   = cfg_in.lsb_first ? fifo_data :
                    fifo_data << (5'h1F - cfg_in.len_m1);       // RQ17
        rx_cur    = rx_sh_reg;
        cnt_next  = (state_reg == ST_IDLE || tick) ? DIV_RST :
                    cnt_reg + 1'b1;

        unique case (state_reg)
            ST_IDLE:
            begin
                // Clock rests at the chosen idle level
                sclk_next = cfg_in.cpol;                        // RQ19
                if (fifo_valid)
                begin
                    // Take a word with the set-up of this moment
                    fifo_pop   = 1'b1;                          // RQ13
                    cfg_next   = cfg_in;
                    // Rate kept inside the supported range
                    half_next  = (half_div_in < HALF_LO) ? HALF_LO :
                                 (half_div_in > HALF_HI) ? HALF_HI :
                                 half_div_in;                   // RQ4
                    edge_next  = EDGE_RST;
                    rx_sh_next = WORD_RST;
                    tx_sh_next = aligned;
                    // Phase 0 puts the first bit out before any edge
                    if (!cfg_in.cpha)
                    begin
                        mosi_next  = cfg_in.lsb_first ? aligned[0] :
                                     aligned[SPIM_DATA_W-1];    // RQ5 RQ7
                        tx_sh_next = cfg_in.lsb_first ? aligned >> 1 :
                                     aligned << 1;
                    end
                    state_next = ST_LEAD;
                end
            end
            ST_LEAD:
            begin
                // Select set-up of two half periods: this one plus the one before the first edge
                if (tick)
                    state_next = ST_SHIFT;
            end
            ST_SHIFT:
            begin
                if (tick)
                begin
                    // Edges with even index are leading edges
                    if (edge_reg < last_edge)
                    begin
                        sclk_next = ~sclk_reg;                  // RQ1
                        launch    = cfg_reg.cpha ? !edge_reg[0] :
                                    edge_reg[0];   // RQ5 RQ6 RQ7 RQ8
                    end
                    // Sample on the opposite edge, or one later
                    sample = (edge_reg >= first_smp) &&
                             (edge_reg[0] ==
                              (cfg_reg.cpha ^ cfg_reg.late_sample))
                             && (edge_reg <=
                                 last_edge + first_smp - 7'h02); // RQ18
                    edge_next = edge_reg + 1'b1;
                    if (edge_reg == last_edge)
                    begin
                        finish     = 1'b1;                      // RQ3
                        state_next = ST_GAP;
                    end
                end
            end
            ST_GAP:
            begin
                // Idle half period with automatic select released
                if (tick)
                    state_next = ST_IDLE;
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase

        // Each launched bit is matched by one sampled bit, except the extra bit phase 0 launches on the last edge
        if (launch)
        begin
            mosi_next  = cfg_reg.lsb_first ? tx_sh_reg[0] :
                         tx_sh_reg[SPIM_DATA_W-1];              // RQ2
            tx_sh_next = cfg_reg.lsb_first ? tx_sh_reg >> 1 :
                         tx_sh_reg << 1;
        end
        if (sample)
        begin
            rx_cur = cfg_reg.lsb_first ?
                     {miso_sync, rx_sh_reg[SPIM_DATA_W-1:1]} :
                     {rx_sh_reg[SPIM_DATA_W-2:0], miso_sync};   // RQ2
        end
        rx_sh_next = (state_reg == ST_IDLE) ? rx_sh_next : rx_cur;

        // Right-align so the word holds exactly the length sent
        if (finish)
        begin
            rx_word_next  = cfg_reg.lsb_first ?
                            rx_cur >> (5'h1F - cfg_reg.len_m1) :
                            rx_cur;                             // RQ14
            rx_valid_next = 1'b1;
        end
    end

    // Select, status and interrupt next values
    always_comb
    begin
        auto_vec = '0;
        // Automatic select only in lead and shift states; index above 4 is none
        if (cfg_next.auto_sel &&
            (state_next == ST_LEAD || state_next == ST_SHIFT) &&
            (cfg_next.sel_idx < 3'(SPIM_SEL_N)))
            auto_vec[cfg_next.sel_idx] = 1'b1;                  // RQ11
        // Manual bits hold across transactions
        sel_n_next = ~(auto_vec | manual_sel_in);               // RQ9 RQ11
        busy_next  = state_next != ST_IDLE;
        // Completion wins over a clear in the same cycle
        done_next  = finish ? 1'b1 :
                     (done_clr_in ? 1'b0 : done_reg);           // RQ16
        irq_next   = done_next && irq_en_in;                    // RQ16
    end

    // Engine registers
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            state_reg    <= ST_IDLE;                            // RQ19
            cfg_reg      <= CFG_RST;
            half_reg     <= DIV_RST;
            cnt_reg      <= DIV_RST;
            edge_reg     <= EDGE_RST;
            tx_sh_reg    <= WORD_RST;
            rx_sh_reg    <= WORD_RST;
            sclk_reg     <= 1'b0;
            mosi_reg     <= 1'b0;
            rx_word_reg  <= WORD_RST;
            rx_valid_reg <= 1'b0;
        end
        else
        begin
            state_reg    <= state_next;
            cfg_reg      <= cfg_next;
            half_reg     <= half_next;
            cnt_reg      <= cnt_next;
            edge_reg     <= edge_next;
            tx_sh_reg    <= tx_sh_next;
            rx_sh_reg    <= rx_sh_next;
            sclk_reg     <= sclk_next;
            mosi_reg     <= mosi_next;
            rx_word_reg  <= rx_word_next;
            rx_valid_reg <= rx_valid_next;
        end
    end

    // Select and status registers
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            sel_n_reg <= SEL_RST;                               // RQ19
            busy_reg  <= 1'b0;
            done_reg  <= 1'b0;
            irq_reg   <= 1'b0;
        end
        else
        begin
            sel_n_reg <= sel_n_next;
            busy_reg  <= busy_next;
            done_reg  <= done_next;
            irq_reg   <= irq_next;
        end
    end

    // Outputs straight from flops
    assign serial_clk_out           = sclk_reg;
    assign master_out_line_out      = mosi_reg;
    assign slave_select_zero_n_out  = sel_n_reg[0];
    assign slave_select_one_n_out   = sel_n_reg[1];
    assign slave_select_two_n_out   = sel_n_reg[2];
    assign slave_select_three_n_out = sel_n_reg[3];
    assign slave_select_four_n_out  = sel_n_reg[4];
    assign rx_data_out              = rx_word_reg;
    assign rx_valid_out             = rx_valid_reg;
    assign busy_out                 = busy_reg;
    assign done_out                 = done_reg;
    assign irq_out                  = irq_reg;

    // Checker helper: clock edges counted per transfer
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in || state_reg == ST_IDLE)
            toggles_reg <= EDGE_RST;
        else if (sclk_next != sclk_reg)
            toggles_reg <= toggles_reg + 1'b1;
    end

    property p_edge_count;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        finish |-> (toggles_reg == last_edge);
    endproperty
    a_edge_count: assert property (p_edge_count) // RQ3
        else $error("wrong number of clock edges");

    property p_idle_level;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_IDLE) ##1 (state_reg == ST_IDLE)
        |-> (serial_clk_out == $past(cfg_in.cpol));
    endproperty
    a_idle_level: assert property (p_idle_level) // RQ19
        else $error("clock not at idle level");

    property p_launch_edge;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_SHIFT && $changed(master_out_line_out))
        |-> (serial_clk_out == (cfg_reg.cpol ^ cfg_reg.cpha));
    endproperty
    a_launch_edge: assert property (p_launch_edge) // RQ5
        else $error("data changed on the wrong edge");

    property p_clk_only_shift;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        $changed(serial_clk_out) && !$past(state_reg == ST_IDLE)
        |-> $past(state_reg == ST_SHIFT) && $past(tick);
    endproperty
    a_clk_only_shift: assert property (p_clk_only_shift) // RQ1
        else $error("clock toggled outside shifting");

    property p_one_auto_sel;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        ($past(manual_sel_in) == '0) |-> $onehot0(~sel_n_reg);
    endproperty
    a_one_auto_sel: assert property (p_one_auto_sel) // RQ9
        else $error("more than one select asserted");

    property p_sel_drop;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_reg == ST_GAP && manual_sel_in == '0)
        |=> (sel_n_reg == SEL_RST);
    endproperty
    a_sel_drop: assert property (p_sel_drop) // RQ11
        else $error("select held between transactions");

    property p_done_set;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        finish |=> done_out && rx_valid_out ##1 !rx_valid_out;
    endproperty
    a_done_set: assert property (p_done_set) // RQ16
        else $error("completion not flagged");

    property p_irq_mask;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (done_out && irq_en_in && !done_clr_in) |=> irq_out;
    endproperty
    a_irq_mask: assert property (p_irq_mask) // RQ16
        else $error("masked interrupt missing");

    property p_rate_floor;
        @(posedge core_clk_in) disable iff (!rst_n_in)
        (state_reg != ST_IDLE) |-> (half_reg >= HALF_LO);
    endproperty
    a_rate_floor: assert property (p_rate_floor) // RQ4
        else $error("serial clock above the limit");

endmodule // spim_master

// ==== verif/spim_slave_model.sv ====
// Purpose: Serial slave model that echoes inverted master data
// Assumes: Bench hands it the mode bits in use
// Notes:   While deselected its output toggles, never holds
`timescale 1ns/1ps
module spim_slave_model (
    // Clock and pins
    input  wire logic   core_clk_in,
    input  wire logic   sclk_in,
    input  wire logic   mosi_in,
    input  wire logic   sel_n_in,
    // Mode in use
    input  wire logic   cpol_in,
    input  wire logic   cpha_in,
    // Answer and capture
    output logic        miso_out,
    output logic [31:0] got_out
);
    initial miso_out = 1'b0;
    initial got_out = 32'h0000_0000;
    // Inverted echo lags a cycle, like a slow slave
    always @(posedge core_clk_in)
        miso_out <= sel_n_in ? ~miso_out : ~mosi_in;
    // Fresh capture each select
    always @(negedge sel_n_in)
        got_out <= 32'h0000_0000;
    // Capture on the sampling edge of the mode
    always @(sclk_in)
        if (!sel_n_in && sclk_in == !(cpol_in ^ cpha_in))
            got_out <= {got_out[30:0], mosi_in};
endmodule // spim_slave_model

// ==== verif/test_spim_master.sv ====
// Purpose: Directed bench for the serial master
// Assumes: Inputs change on falling clock edges
// Notes:   Slave echoes inverted bits, so rx is known
`timescale 1ns/1ps
module test_spim_master import spim_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, irq_en = 1'b0, clr = 1'b0, tv = 1'b0;
    logic [31:0] td = 32'h0000_0000, rxd, got;
    logic [8:0] hdiv = 9'h004;
    logic [4:0] msel = 5'h00;
    wire  [4:0] seln;
    spim_cfg_t cfg = CFG_RST;
    logic tr, rv, bsy, dn, irq, sclk, mosi, miso;
    int error_cnt = 0, compares = 0, edges = 0;
    spim_master uut (.core_clk_in(clk), .rst_n_in(rst_n), .cfg_in(cfg),
        .half_div_in(hdiv), .manual_sel_in(msel), .irq_en_in(irq_en),
        .done_clr_in(clr), .tx_valid_in(tv), .tx_data_in(td),
        .tx_ready_out(tr), .rx_data_out(rxd), .rx_valid_out(rv),
        .busy_out(bsy), .done_out(dn), .irq_out(irq),
        .serial_clk_out(sclk), .master_out_line_out(mosi),
        .master_in_line_in(miso), .slave_select_zero_n_out(seln[0]),
        .slave_select_one_n_out(seln[1]), .slave_select_two_n_out(seln[2]),
        .slave_select_three_n_out(seln[3]),
        .slave_select_four_n_out(seln[4]));
    spim_slave_model sm (.core_clk_in(clk), .sclk_in(sclk), .mosi_in(mosi),
        .sel_n_in(seln[0]), .cpol_in(cfg.cpol), .cpha_in(cfg.cpha),
        .miso_out(miso), .got_out(got));
    initial forever #5 clk = ~clk;
    // Serial clock toggles, cleared per transfer
    always @(sclk) edges++;
    task automatic check(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e)
        begin
            $display("wrong value %s exp %h seen %h", nm, e, s);
            error_cnt++;
        end
    endtask
    // Hold valid until ready is seen for the coming edge
    task automatic push(input logic [31:0] d);
        @(negedge clk);
        tv = 1'b1;
        td = d;
        while (tr !== 1'b1) @(negedge clk);
        @(negedge clk);
        tv = 1'b0;
    endtask
    task automatic wait_rx();
        for (int k = 0; k < 30000 && rv !== 1'b1; k++) @(negedge clk);
        check("rx_valid", rv, 1'b1);
        @(negedge clk);
    endtask
    task automatic xfer(input int i, input logic [4:0] len, input logic au);
        logic [31:0] d, m, ex;
        d = 32'hC3A5_96E1 ^ i;
        m = 32'hFFFF_FFFF >> (5'd31 - len);
        ex = d & m;
        if (i[2])
            for (int j = 0; j <= len; j++) ex[len - j] = d[j];
        cfg = '{i[1], i[0], i[2], i[2] ^ i[0], len, 3'h0, au};
        msel = {4'h0, ~au};
        irq_en = i[0];
        repeat (3) @(negedge clk);
        edges = 0;
        push(d);
        wait_rx();
        check("rx_data", rxd, ~d & m);
        repeat (3) @(negedge clk);
        check("slave_got", got & m, ex);
        check("edges", edges, 2 * (len + 1));
        check("sclk_idle", sclk, i[1]);
        check("selects", seln, {4'hF, au});
        check("done", dn, 1'b1);
        check("irq", irq, i[0]);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        @(negedge clk);
        check("done_clr", dn, 1'b0);
    endtask
    task automatic close_out();
        $display("errors %0d compares %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial
    begin
        #400000;
        error_cnt++;
        close_out();
    end
    initial
    begin
        repeat (16) @(negedge clk);
        check("rst_sel", seln, 5'h1F);
        check("rst_busy", {bsy, sclk, tr}, 3'h0);
        @(negedge clk);
        rst_n = 1'b1;
        // All modes, orders and sample delays
        for (int i = 0; i < 8; i++) xfer(i, 5'(31 - i * 9), 1'b1);
        xfer(1, 5'd7, 1'b0);
        hdiv = 9'd400;
        xfer(0, 5'd0, 1'b1);
        // Below the floor: clamped, so the echo still lines up
        hdiv = 9'h002;
        // Dummy words behind a busy engine, then drain
        repeat (9) push(32'h0F0F_F0F0);
        check("fifo_full", tr, 1'b0);
        repeat (9) wait_rx();
        // One-bit reads of bit 0, echoed inverted
        check("rx_dummy", rxd, 32'h0000_0001);
        // Gap of one half period keeps busy high a while
        repeat (5) @(negedge clk);
        check("fifo_empty", {tr, bsy}, 2'h2);
        close_out();
    end
endmodule // test_spim_master
